// ---- shared/fpr_defs.svh ----
// Constants for the flash protection and read-parameter register block.
`ifndef FPR_DEFS_SVH
`define FPR_DEFS_SVH

`define FPR_CMD_SET_RP_PERSIST 8'h65
`define FPR_CMD_SET_RP_VOL_A 8'hC0
`define FPR_CMD_SET_RP_VOL_B 8'h63
`define FPR_CMD_WRITE_FUNC 8'h42

`define FPR_RP_RESET 8'h00
`define FPR_FN_UPPER_RESET 7'h00

`define FPR_FN_RST_DISABLE 0
`define FPR_FN_RESERVED 1
`define FPR_FN_PROG_SUSP 2
`define FPR_FN_ERASE_SUSP 3
`define FPR_FN_LOCK_LSB 4
`define FPR_FN_LOCK_MSB 7

`define FPR_RP_PIN_SEL 7
`define FPR_RP_DUMMY_MSB 6
`define FPR_RP_DUMMY_LSB 3
`define FPR_RP_WRAP 2
`define FPR_RP_BURST_MSB 1
`define FPR_RP_BURST_LSB 0

`define FPR_DUMMY_FAST_SPI 4'h8
`define FPR_DUMMY_FAST_QPI 4'h6
`define FPR_DUMMY_DUAL_OUT 4'h8
`define FPR_DUMMY_DUAL_IO 4'h4
`define FPR_DUMMY_QUAD_OUT 4'h8
`define FPR_DUMMY_QUAD_IO 4'h6

`define FPR_BURST_BASE 7'h08
`define FPR_BLOCKS 64

`endif

// ---- shared/fpr_pkg.sv ----
// Types shared by the flash protection and read-parameter register block.
`default_nettype none
package fpr_pkg;
    typedef enum logic [1:0] {
        FPR_PIN_HOLD = 2'b00,
        FPR_PIN_RESET = 2'b01,
        FPR_PIN_DATA = 2'b10
    } fpr_pin_mode_t;

    typedef enum logic [2:0] {
        FPR_RD_FAST_SPI = 3'b000,
        FPR_RD_FAST_QPI = 3'b001,
        FPR_RD_DUAL_OUT = 3'b010,
        FPR_RD_DUAL_IO = 3'b011,
        FPR_RD_QUAD_OUT = 3'b100,
        FPR_RD_QUAD_IO = 3'b101
    } fpr_read_kind_t;

    typedef enum logic {
        FPR_ST_POWERUP = 1'b0,
        FPR_ST_READY = 1'b1
    } fpr_state_t;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
    } fpr_cmd_t;
endpackage
`default_nettype wire

// ---- hw/fpr_sync.sv ----
// Two-flop synchroniser for levels and toggles crossing into a clock domain.
`timescale 1ns/100ps
`default_nettype none
module fpr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("fpr_sync needs WIDTH of at least one");
        end
    endgenerate

    always_comb begin
        next_meta = d;
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- hw/fpr_protect_decode.sv ----
// Decoder from the four-bit protection field to a per-block protect mask.
`timescale 1ns/100ps
`default_nettype none
`include "fpr_defs.svh"
module fpr_protect_decode #(
    parameter int NUM_BLOCKS = `FPR_BLOCKS
) (
    input wire logic [3:0] protect_field,
    output logic [NUM_BLOCKS-1:0] protect_mask
);
    localparam int CW = $clog2(NUM_BLOCKS) + 1;
    localparam logic [CW-1:0] NUM_C = CW'(NUM_BLOCKS);
    logic [CW-1:0] top_cnt;
    logic [CW-1:0] bot_cnt;
    logic all_blk;

    generate
        if (NUM_BLOCKS < 64) begin : g_bad_blocks
            $error("fpr_protect_decode needs at least 64 blocks");
        end
    endgenerate

    // Codes 1..6 cover the top, 9..14 the bottom, 7 and 8 everything.
    always_comb begin
        top_cnt = '0;
        bot_cnt = '0;
        all_blk = 1'b0;
        case (protect_field)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: top_cnt = CW'(1) << (protect_field - 4'h1);
            4'h7, 4'h8: all_blk = 1'b1;
            4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE: bot_cnt = CW'(1) << (4'hE - protect_field);
            default: all_blk = 1'b0;
        endcase
    end

    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
        localparam logic [CW-1:0] IDX = CW'(b);
        assign protect_mask[b] = all_blk | (IDX >= NUM_C - top_cnt) | (IDX < bot_cnt);
    end
endmodule
`default_nettype wire

// ---- hw/fpr_top.sv ----
// Protection decode, function register and read-parameter registers of a serial flash.
`timescale 1ns/100ps
`default_nettype none
`include "fpr_defs.svh"
module fpr_top #(
    parameter logic RESET_DISABLE_DEFAULT = 1'b0,
    parameter logic HAS_DEDICATED_RESET = 1'b1,
    parameter logic [7:0] WRITE_ENABLE_CODE = 8'h06,
    parameter int NUM_BLOCKS = `FPR_BLOCKS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire fpr_pkg::fpr_cmd_t cmd_in,
    output logic cmd_ready,
    input wire logic program_active,
    input wire logic erase_active,
    input wire logic suspend_cmd,
    input wire logic resume_cmd,
    input wire logic quad_enable_bit,
    input wire logic quad_command_mode,
    input wire logic [3:0] protect_field,
    input wire fpr_pkg::fpr_read_kind_t read_kind,
    input wire logic ir_prog_req,
    input wire logic [1:0] ir_prog_row,
    output logic ir_prog_grant,
    output logic ir_prog_refused,
    output logic [7:0] function_lock_suspend,
    output logic [7:0] read_parameters,
    output logic [7:0] read_parameters_persistent,
    output logic write_enable_latch,
    output logic [NUM_BLOCKS-1:0] protected_blocks,
    output fpr_pkg::fpr_pin_mode_t shared_pin_mode,
    output logic dedicated_reset_active,
    output logic [3:0] dummy_cycles,
    output logic wrap_enable,
    output logic [6:0] burst_bytes
);
    generate
        if (NUM_BLOCKS < 64) begin : g_bad_blocks
            $error("fpr_top needs at least 64 blocks");
        end
    endgenerate

    // Link side: a command is held stable until the core toggles back.
    logic link_rst;
    logic req_tgl;
    logic next_req_tgl;
    logic ack_sync;
    logic req_seen;
    fpr_pkg::fpr_cmd_t hold;
    fpr_pkg::fpr_cmd_t next_hold;

    fpr_sync #(.WIDTH(1)) u_rst_sync (
        .clk(link_clk),
        .rst(1'b0),
        .d(reset),
        .q(link_rst)
    );

    fpr_sync #(.WIDTH(1)) u_ack_sync (
        .clk(link_clk),
        .rst(link_rst),
        .d(req_seen),
        .q(ack_sync)
    );

    assign cmd_ready = !link_rst && (ack_sync == req_tgl);

    always_comb begin
        next_req_tgl = req_tgl;
        next_hold = hold;
        if (cmd_valid && cmd_ready) begin
            next_req_tgl = !req_tgl;
            next_hold = cmd_in;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            req_tgl <= 1'b0;
            hold <= '0;
        end else begin
            req_tgl <= next_req_tgl;
            hold <= next_hold;
        end
    end

    // Core side: registers and the power-up load.
    logic req_sync;
    logic next_req_seen;
    logic new_cmd;
    fpr_pkg::fpr_state_t state;
    fpr_pkg::fpr_state_t next_state;
    logic [7:0] nv_rp;
    logic [7:0] next_nv_rp;
    logic [7:0] vol_rp;
    logic [7:0] next_vol_rp;
    logic [7:0] func;
    logic [7:0] next_func;
    logic wel;
    logic next_wel;

    fpr_sync #(.WIDTH(1)) u_req_sync (
        .clk(ref_clk),
        .rst(reset),
        .d(req_tgl),
        .q(req_sync)
    );

    // Commands wait while the power-up load runs, so none is lost.
    assign new_cmd = (req_sync != req_seen) && (state == fpr_pkg::FPR_ST_READY);

    always_comb begin
        next_state = state;
        next_nv_rp = nv_rp;
        next_vol_rp = vol_rp;
        next_func = func;
        next_wel = wel;
        next_req_seen = req_seen;
        case (state)
            fpr_pkg::FPR_ST_POWERUP: begin
                next_vol_rp = nv_rp;
                next_state = fpr_pkg::FPR_ST_READY;
            end
            fpr_pkg::FPR_ST_READY: begin
                if (new_cmd) begin
                    next_req_seen = req_sync;
                    if (hold.code == WRITE_ENABLE_CODE) begin
                        next_wel = 1'b1;
                    end else if (hold.code == `FPR_CMD_SET_RP_PERSIST) begin
                        // Without a prior write enable the persistent write is dropped.
                        if (wel) begin
                            next_nv_rp = hold.data;
                        end
                        next_wel = 1'b0;
                    end else if (hold.code == `FPR_CMD_SET_RP_VOL_A || hold.code == `FPR_CMD_SET_RP_VOL_B) begin
                        next_vol_rp = hold.data;
                    end else if (hold.code == `FPR_CMD_WRITE_FUNC) begin
                        if (wel) begin
                            next_func[`FPR_FN_RST_DISABLE] = func[`FPR_FN_RST_DISABLE]
                                | hold.data[`FPR_FN_RST_DISABLE];
                            next_func[`FPR_FN_LOCK_MSB:`FPR_FN_LOCK_LSB] = func[`FPR_FN_LOCK_MSB:`FPR_FN_LOCK_LSB]
                                | hold.data[`FPR_FN_LOCK_MSB:`FPR_FN_LOCK_LSB];
                        end
                        next_wel = 1'b0;
                    end
                end
            end
            default: next_state = fpr_pkg::FPR_ST_POWERUP;
        endcase
        // Resume clears first so that a same-cycle suspend still sets.
        if (resume_cmd) begin
            next_func[`FPR_FN_PROG_SUSP] = 1'b0;
            next_func[`FPR_FN_ERASE_SUSP] = 1'b0;
        end
        if (suspend_cmd && program_active) begin
            next_func[`FPR_FN_PROG_SUSP] = 1'b1;
        end
        if (suspend_cmd && erase_active) begin
            next_func[`FPR_FN_ERASE_SUSP] = 1'b1;
        end
        next_func[`FPR_FN_RESERVED] = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= fpr_pkg::FPR_ST_POWERUP;
            nv_rp <= `FPR_RP_RESET;
            vol_rp <= `FPR_RP_RESET;
            func <= {`FPR_FN_UPPER_RESET, RESET_DISABLE_DEFAULT};
            wel <= 1'b0;
            req_seen <= 1'b0;
        end else begin
            state <= next_state;
            nv_rp <= next_nv_rp;
            vol_rp <= next_vol_rp;
            func <= next_func;
            wel <= next_wel;
            req_seen <= next_req_seen;
        end
    end

    assign function_lock_suspend = func;
    assign read_parameters = vol_rp;
    assign read_parameters_persistent = nv_rp;
    assign write_enable_latch = wel;

    // Derived controls, registered so every data output comes from a flop.
    logic [NUM_BLOCKS-1:0] mask;
    logic [NUM_BLOCKS-1:0] next_prot;
    fpr_pkg::fpr_pin_mode_t next_pin;
    logic next_ded;
    logic [3:0] next_dummy;
    logic [3:0] dummy_field;
    logic next_wrap;
    logic [6:0] next_burst;
    logic row_locked;
    logic next_grant;
    logic next_refused;

    fpr_protect_decode #(.NUM_BLOCKS(NUM_BLOCKS)) u_decode (
        .protect_field(protect_field),
        .protect_mask(mask)
    );

    assign dummy_field = vol_rp[`FPR_RP_DUMMY_MSB:`FPR_RP_DUMMY_LSB];
    assign row_locked = func[`FPR_FN_LOCK_LSB + int'(ir_prog_row)];

    always_comb begin
        next_prot = mask;
        next_ded = HAS_DEDICATED_RESET && !func[`FPR_FN_RST_DISABLE];
        if (quad_enable_bit || quad_command_mode) begin
            next_pin = fpr_pkg::FPR_PIN_DATA;
        end else if (next_ded) begin
            next_pin = fpr_pkg::FPR_PIN_HOLD;
        end else if (vol_rp[`FPR_RP_PIN_SEL]) begin
            next_pin = fpr_pkg::FPR_PIN_RESET;
        end else begin
            next_pin = fpr_pkg::FPR_PIN_HOLD;
        end
        if (dummy_field != 4'h0) begin
            next_dummy = dummy_field;
        end else begin
            case (read_kind)
                fpr_pkg::FPR_RD_FAST_SPI: next_dummy = `FPR_DUMMY_FAST_SPI;
                fpr_pkg::FPR_RD_FAST_QPI: next_dummy = `FPR_DUMMY_FAST_QPI;
                fpr_pkg::FPR_RD_DUAL_OUT: next_dummy = `FPR_DUMMY_DUAL_OUT;
                fpr_pkg::FPR_RD_DUAL_IO: next_dummy = `FPR_DUMMY_DUAL_IO;
                fpr_pkg::FPR_RD_QUAD_OUT: next_dummy = `FPR_DUMMY_QUAD_OUT;
                fpr_pkg::FPR_RD_QUAD_IO: next_dummy = `FPR_DUMMY_QUAD_IO;
                default: next_dummy = `FPR_DUMMY_FAST_SPI;
            endcase
        end
        next_wrap = vol_rp[`FPR_RP_WRAP];
        // A zero burst size tells the read path to run through the whole array.
        next_burst = next_wrap ? (`FPR_BURST_BASE << vol_rp[`FPR_RP_BURST_MSB:`FPR_RP_BURST_LSB]) : 7'h00;
        next_grant = ir_prog_req && !row_locked;
        next_refused = ir_prog_req && row_locked;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            protected_blocks <= '0;
            shared_pin_mode <= fpr_pkg::FPR_PIN_HOLD;
            dedicated_reset_active <= 1'b0;
            dummy_cycles <= `FPR_DUMMY_FAST_SPI;
            wrap_enable <= 1'b0;
            burst_bytes <= 7'h00;
            ir_prog_grant <= 1'b0;
            ir_prog_refused <= 1'b0;
        end else begin
            protected_blocks <= next_prot;
            shared_pin_mode <= next_pin;
            dedicated_reset_active <= next_ded;
            dummy_cycles <= next_dummy;
            wrap_enable <= next_wrap;
            burst_bytes <= next_burst;
            ir_prog_grant <= next_grant;
            ir_prog_refused <= next_refused;
        end
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    chk_protect_all_set: assert property ((protect_field == 4'h7 || protect_field == 4'h8)
        |=> &protected_blocks) else $error("All-block code did not protect every block.");
    chk_protect_none_set: assert property ((protect_field == 4'h0 || protect_field == 4'hF)
        |=> protected_blocks == '0) else $error("No-protect code left a block protected.");
    chk_otp_never_clears: assert property (
        (~func[7:4] & $past(func[7:4])) == 4'h0 && !$fell(func[0]))
        else $error("A one-time bit went back to zero.");
    chk_lock_refuses_row: assert property ((ir_prog_req && row_locked)
        |=> ir_prog_refused && !ir_prog_grant) else $error("Locked row program was not refused.");
    chk_prog_susp_set: assert property ((suspend_cmd && program_active)
        |=> func[2]) else $error("Program-suspended flag did not set.");
    chk_prog_susp_hold: assert property ((func[2] && !resume_cmd)
        |=> func[2]) else $error("Program-suspended flag dropped without a resume.");
    chk_erase_susp_clear: assert property ((resume_cmd && !suspend_cmd)
        |=> !func[3]) else $error("Erase-suspended flag did not clear on resume.");
    chk_powerup_load_copy: assert property ((state == fpr_pkg::FPR_ST_POWERUP)
        |=> vol_rp == $past(nv_rp) ##1 state == fpr_pkg::FPR_ST_READY) else $error("Power-up load failed.");
    chk_pin_data_mode: assert property ((quad_enable_bit || quad_command_mode)
        |=> shared_pin_mode == fpr_pkg::FPR_PIN_DATA) else $error("Shared pin not data in quad mode.");
    chk_pin_hold_forced: assert property ((!quad_enable_bit && !quad_command_mode && HAS_DEDICATED_RESET
        && !func[0]) |=> shared_pin_mode == fpr_pkg::FPR_PIN_HOLD) else $error("Shared pin not hold.");
    chk_dummy_field_used: assert property ((dummy_field != 4'h0)
        |=> dummy_cycles == $past(dummy_field)) else $error("Dummy count ignored the field.");
    chk_dummy_default_io: assert property ((dummy_field == 4'h0 && read_kind == fpr_pkg::FPR_RD_DUAL_IO)
        |=> dummy_cycles == 4'h4) else $error("Dual I/O default dummy count wrong.");
    chk_burst_len_code: assert property (vol_rp[2]
        |=> burst_bytes == (7'h08 << $past(vol_rp[1:0]))) else $error("Burst length decode wrong.");
    chk_persist_needs_wel: assert property ((new_cmd && hold.code == 8'h65 && !wel)
        |=> nv_rp == $past(nv_rp)) else $error("Persistent copy written without write enable.");
    chk_reserved_zero: assert property (func[1] == 1'b0)
        else $error("Reserved function bit is not zero.");
endmodule
`default_nettype wire

// ---- testbench/fpr_host_model.sv ----
// Host-side command source on the link clock for the register block.
`timescale 1ns/100ps
`default_nettype none
module fpr_host_model #(
    parameter logic [7:0] WRITE_ENABLE_CODE = 8'h06
) (
    input wire logic link_clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output fpr_pkg::fpr_cmd_t cmd_in
);
    initial begin
        cmd_valid = 1'b0;
        cmd_in = 16'h0000;
    end

    // Ready is combinational, so it is read mid-cycle where it has settled.
    // A ready that never returns is left to the bench watchdog, which counts it.
    task automatic wait_ready;
        do begin
            @(negedge link_clk);
        end while (cmd_ready !== 1'b1);
    endtask

    // Code and data go out together and stay put until the taking edge.
    task automatic send(input logic [7:0] code, input logic [7:0] data);
        wait_ready();
        @(posedge link_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_in = {code, data};
        wait_ready();
        @(posedge link_clk);
        #1;
        cmd_valid = 1'b0;
        // A released line must not look like a held one.
        cmd_in = ~cmd_in;
        wait_ready();
    endtask

    // Persistent and function writes are preceded by the write enable.
    task automatic guarded(input logic [7:0] code, input logic [7:0] data);
        send(WRITE_ENABLE_CODE, 8'h00);
        send(code, data);
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the protection, function and read-parameter block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic program_active = 1'b0;
    logic erase_active = 1'b0;
    logic suspend_cmd = 1'b0;
    logic resume_cmd = 1'b0;
    logic quad_enable_bit = 1'b0;
    logic quad_command_mode = 1'b0;
    logic [3:0] protect_field = 4'h0;
    fpr_pkg::fpr_read_kind_t read_kind = fpr_pkg::FPR_RD_FAST_SPI;
    logic ir_prog_req = 1'b0;
    logic [1:0] ir_prog_row = 2'h0;
    logic cmd_valid;
    fpr_pkg::fpr_cmd_t cmd_in;
    logic cmd_ready;
    logic ir_prog_grant;
    logic ir_prog_refused;
    logic [7:0] function_lock_suspend;
    logic [7:0] read_parameters;
    logic [7:0] read_parameters_persistent;
    logic write_enable_latch;
    logic [63:0] protected_blocks;
    fpr_pkg::fpr_pin_mode_t shared_pin_mode;
    logic dedicated_reset_active;
    logic [3:0] dummy_cycles;
    logic wrap_enable;
    logic [6:0] burst_bytes;
    logic [3:0] d;
    logic alt = 1'b0;
    int errors = 0;
    int compares = 0;
    // Each row is field, then top flag and block count of the range.
    logic [11:0] prot_rows [16] = '{12'h000, 12'h181, 12'h282, 12'h384, 12'h488, 12'h590, 12'h6A0, 12'h740,
        12'h840, 12'h920, 12'hA10, 12'hB08, 12'hC04, 12'hD02, 12'hE01, 12'hF00};
    logic [3:0] dflt [6] = '{4'h8, 4'h6, 4'h8, 4'h4, 4'h8, 4'h6};

    always #2 ref_clk = ~ref_clk;
    // The offset keeps link edges away from core edges.
    always begin
        if ($time == 0) #1.3;
        #32 link_clk = ~link_clk;
    end

    fpr_top i_fpr_top (
        .ref_clk(ref_clk),
        .reset(reset),
        .link_clk(link_clk),
        .cmd_valid(cmd_valid),
        .cmd_in(cmd_in),
        .cmd_ready(cmd_ready),
        .program_active(program_active),
        .erase_active(erase_active),
        .suspend_cmd(suspend_cmd),
        .resume_cmd(resume_cmd),
        .quad_enable_bit(quad_enable_bit),
        .quad_command_mode(quad_command_mode),
        .protect_field(protect_field),
        .read_kind(read_kind),
        .ir_prog_req(ir_prog_req),
        .ir_prog_row(ir_prog_row),
        .ir_prog_grant(ir_prog_grant),
        .ir_prog_refused(ir_prog_refused),
        .function_lock_suspend(function_lock_suspend),
        .read_parameters(read_parameters),
        .read_parameters_persistent(read_parameters_persistent),
        .write_enable_latch(write_enable_latch),
        .protected_blocks(protected_blocks),
        .shared_pin_mode(shared_pin_mode),
        .dedicated_reset_active(dedicated_reset_active),
        .dummy_cycles(dummy_cycles),
        .wrap_enable(wrap_enable),
        .burst_bytes(burst_bytes)
    );

    fpr_host_model i_fpr_host_model (
        .link_clk(link_clk),
        .cmd_ready(cmd_ready),
        .cmd_valid(cmd_valid),
        .cmd_in(cmd_in)
    );

    function automatic logic [63:0] exp_mask(input logic [7:0] r);
        return r[7] ? ~(64'hFFFF_FFFF_FFFF_FFFF >> r[6:0]) : (64'h1 << r[6:0]) - 64'h1;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reset spans several link cycles so the link side sees it too.
    task automatic do_reset;
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (10) @(posedge link_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic settle;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic vol(input logic [7:0] data);
        alt = ~alt;
        i_fpr_host_model.send(alt ? 8'hC0 : 8'h63, data);
        settle();
    endtask

    task automatic pulse(input logic s);
        @(negedge ref_clk);
        suspend_cmd = s;
        resume_cmd = ~s;
        @(negedge ref_clk);
        suspend_cmd = 1'b0;
        resume_cmd = 1'b0;
    endtask

    initial begin
        fork
            begin
                #150000;
                errors++;
                test_done();
            end
        join_none
        do_reset();
        check(function_lock_suspend, 8'h00);
        check(read_parameters, 8'h00);
        check(read_parameters_persistent, 8'h00);
        check(shared_pin_mode, fpr_pkg::FPR_PIN_HOLD);
        check(dedicated_reset_active, 1'b1);
        check(dummy_cycles, 4'h8);
        check(burst_bytes, 7'h00);
        for (int i = 0; i < 16; i++) begin
            protect_field = prot_rows[i][11:8];
            settle();
            check(protected_blocks, exp_mask(prot_rows[i][7:0]));
        end
        for (int k = 0; k < 6; k++) begin
            read_kind = fpr_pkg::fpr_read_kind_t'(k[2:0]);
            settle();
            check(dummy_cycles, dflt[k]);
        end
        for (int b = 0; b < 4; b++) begin
            d = 4'(b * 14 + 1);
            vol({1'b1, d, 1'b1, 2'(b)});
            check(read_parameters, {1'b1, d, 1'b1, 2'(b)});
            check(dummy_cycles, d);
            check(wrap_enable, 1'b1);
            check(burst_bytes, 7'h08 << b);
            check(shared_pin_mode, fpr_pkg::FPR_PIN_HOLD);
        end
        check(read_parameters_persistent, 8'h00);
        vol(8'h03);
        check(burst_bytes, 7'h00);
        check(wrap_enable, 1'b0);
        check(dummy_cycles, 4'h6);
        i_fpr_host_model.send(8'h65, 8'hA5);
        settle();
        check(read_parameters_persistent, 8'h00);
        i_fpr_host_model.send(8'h06, 8'h00);
        settle();
        check(write_enable_latch, 1'b1);
        i_fpr_host_model.send(8'h65, 8'h5A);
        settle();
        check(read_parameters_persistent, 8'h5A);
        check(read_parameters, 8'h03);
        check(write_enable_latch, 1'b0);
        vol(8'h80);
        check(shared_pin_mode, fpr_pkg::FPR_PIN_HOLD);
        quad_enable_bit = 1'b1;
        settle();
        check(shared_pin_mode, fpr_pkg::FPR_PIN_DATA);
        quad_enable_bit = 1'b0;
        quad_command_mode = 1'b1;
        settle();
        check(shared_pin_mode, fpr_pkg::FPR_PIN_DATA);
        quad_command_mode = 1'b0;
        i_fpr_host_model.guarded(8'h42, 8'h4F);
        settle();
        check(function_lock_suspend, 8'h41);
        check(dedicated_reset_active, 1'b0);
        check(shared_pin_mode, fpr_pkg::FPR_PIN_RESET);
        vol(8'h00);
        check(shared_pin_mode, fpr_pkg::FPR_PIN_HOLD);
        i_fpr_host_model.guarded(8'h42, 8'h00);
        settle();
        check(function_lock_suspend, 8'h41);
        for (int r = 0; r < 5; r++) begin
            @(negedge ref_clk);
            if (r > 0) begin
                check(ir_prog_grant, (r - 1) != 2);
                check(ir_prog_refused, (r - 1) == 2);
            end
            ir_prog_req = (r < 4);
            ir_prog_row = 2'(r);
        end
        pulse(1'b1);
        check(function_lock_suspend, 8'h41);
        erase_active = 1'b1;
        pulse(1'b1);
        check(function_lock_suspend[3:2], 2'b10);
        pulse(1'b0);
        check(function_lock_suspend[3:2], 2'b00);
        erase_active = 1'b0;
        program_active = 1'b1;
        pulse(1'b1);
        check(function_lock_suspend[3:2], 2'b01);
        pulse(1'b0);
        check(function_lock_suspend[3:2], 2'b00);
        // Suspend and resume in one cycle: the set must win.
        @(negedge ref_clk);
        suspend_cmd = 1'b1;
        resume_cmd = 1'b1;
        @(negedge ref_clk);
        suspend_cmd = 1'b0;
        resume_cmd = 1'b0;
        check(function_lock_suspend[3:2], 2'b01);
        pulse(1'b0);
        check(function_lock_suspend[3:2], 2'b00);
        program_active = 1'b0;
        do_reset();
        check(read_parameters, 8'h00);
        check(read_parameters_persistent, 8'h00);
        check(function_lock_suspend, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
